/* File: smr_top.sv */
// Supply monitor reset: reset generator with hold timer and second-monitor flag
// Overview of operation
// [RULE1] The second-monitor flag goes high when the second comparator reports above its trip.
// [RULE2] The second-monitor flag goes low whenever the second comparator reports below trip.
// [RULE3] The flag follows the comparator directly, with no hold delay.
// [RULE4] Reset is driven high whenever the supply comparator reports below the supply trip.
// [RULE5] After power-up reset stays high for the hold interval counted from supply stable.
// [RULE6] The hold interval length is chosen by the two timeout select bits.
// [RULE7] Reset is forced high while the manual reset input is asserted.
// [RULE8] A new low report during the hold count restarts the count from zero.
`timescale 1ns/1ps
`include "smr_cfg.svh"
module smr_top #(
  parameter int            CW    = `SMR_CNT_W,
  parameter logic [CW-1:0] HOLD0 = CW'(`SMR_CLK_HZ / `SMR_MS_PER_S * `SMR_HOLD_MS_0),
  parameter logic [CW-1:0] HOLD1 = CW'(`SMR_CLK_HZ / `SMR_MS_PER_S * `SMR_HOLD_MS_1),
  parameter logic [CW-1:0] HOLD2 = CW'(`SMR_CLK_HZ / `SMR_MS_PER_S * `SMR_HOLD_MS_2),
  parameter logic [CW-1:0] HOLD3 = CW'(`SMR_CLK_HZ / `SMR_MS_PER_S * `SMR_HOLD_MS_3)
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic supply_ok,
  input  wire logic second_monitor_input,
  input  wire logic manual_reset_input,
  input  wire logic timeout_select_bit0,
  input  wire logic timeout_select_bit1,
  output logic      reset_out,
  output logic      reset_oe,
  output logic      second_monitor_flag,
  output logic      second_monitor_oe
);
  import smr_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  smr_state_t st_q;
  smr_state_t st_d;
  logic       rst_d;
  logic       flag_d;
  logic       hold_done;
  smr_sel_t   sel;
  // Select bits sampled live; a change mid-hold takes the new length
  assign sel = {timeout_select_bit1, timeout_select_bit0}; // [RULE6]
  smr_hold_timer #(
    .CW     (CW),
    .LIMIT0 (HOLD0),
    .LIMIT1 (HOLD1),
    .LIMIT2 (HOLD2),
    .LIMIT3 (HOLD3)
  ) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (st_q != SMR_ST_HOLD || !supply_ok), // [RULE8]
    .sel   (sel),
    .done  (hold_done)
  );
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    case (st_q)
      SMR_ST_LOW:  if (supply_ok) st_d = SMR_ST_HOLD; // [RULE5]
      SMR_ST_HOLD: begin
        if (!supply_ok) begin
          st_d = SMR_ST_LOW; // [RULE8]
        end else if (hold_done) begin
          st_d = SMR_ST_RUN; // [RULE5]
        end
      end
      SMR_ST_RUN:  if (!supply_ok) st_d = SMR_ST_LOW; // [RULE4]
      default:     st_d = SMR_ST_LOW;
    endcase
    // Manual reset overrides the state machine  [RULE7]
    rst_d  = (st_d != SMR_ST_RUN) || manual_reset_input; // [RULE4]
    // No filtering: comparator noise passes to the pin  [RULE3]
    flag_d = second_monitor_input; // [RULE1] [RULE2]
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q                <= SMR_ST_LOW;
      reset_out           <= 1'b1;
      second_monitor_flag <= 1'b0;
    end else begin
      st_q                <= st_d;
      reset_out           <= rst_d;
      second_monitor_flag <= flag_d;
    end
  end
  // Open drain: pull low only when the level is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_oe          <= 1'b0;
      second_monitor_oe <= 1'b1;
    end else begin
      reset_oe          <= !rst_d;
      second_monitor_oe <= !flag_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_flag_follow: assert property (@(posedge clk) disable iff (!rst_n)
    second_monitor_input |=> second_monitor_flag) else $error("flag not high"); // [RULE1]
  a_flag_low: assert property (@(posedge clk) disable iff (!rst_n)
    !second_monitor_input |=> !second_monitor_flag) else $error("flag not low"); // [RULE2]
  a_flag_nodelay: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(second_monitor_input) |=> $rose(second_monitor_flag)) else $error("flag delayed"); // [RULE3]
  a_supply_low: assert property (@(posedge clk) disable iff (!rst_n)
    !supply_ok |=> reset_out) else $error("reset not on low supply"); // [RULE4]
  a_hold_min: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(supply_ok) |=> reset_out [*3]) else $error("hold too short"); // [RULE5]
  a_manual: assert property (@(posedge clk) disable iff (!rst_n)
    manual_reset_input |=> reset_out) else $error("manual reset ignored"); // [RULE7]
  a_release_cause: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(reset_out) |-> $past(hold_done) || $past(st_q == SMR_ST_RUN)) else $error("early release"); // [RULE6]
  a_restart_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == SMR_ST_HOLD && !supply_ok) |=> st_q == SMR_ST_LOW ##1 !hold_done)
    else $error("hold not restarted"); // [RULE8]
  ////////////////////////////////////////////////////////////////////////////
  // Checker helpers: an independent count of hold cycles, so a timer that
  // ends early cannot hide behind its own done flag
  logic [CW-1:0] chk_limit;
  logic [CW-1:0] hold_cyc_q;
  logic [CW-1:0] hold_cyc_d;
  always_comb begin
    case (sel)
      2'h0:    chk_limit = HOLD0;
      2'h1:    chk_limit = HOLD1;
      2'h2:    chk_limit = HOLD2;
      default: chk_limit = HOLD3;
    endcase
    // Same clear condition as the timer, but no saturation
    if (st_q == SMR_ST_HOLD && supply_ok) begin
      hold_cyc_d = hold_cyc_q + CW'(1);
    end else begin
      hold_cyc_d = '0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cyc_q <= '0;
    end else begin
      hold_cyc_q <= hold_cyc_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////

  a_flag_fall: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
    $fell(second_monitor_input)
    |=> $fell(second_monitor_flag))
    else $error("flag fall delayed");

  a_flag_pin: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
    second_monitor_oe == !second_monitor_flag)
    else $error("flag pin enable mismatch");

  a_reset_pin: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    reset_oe == !reset_out)
    else $error("reset pin enable mismatch");

  a_low_reset: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    st_q == SMR_ST_LOW
    |-> reset_out)
    else $error("reset low in low state");

  a_run_supply: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    st_q == SMR_ST_RUN
    |-> $past(supply_ok))
    else $error("run without supply");

  a_run_stay: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    (st_q == SMR_ST_RUN && supply_ok)
    |=> st_q == SMR_ST_RUN)
    else $error("run left with good supply");

  a_low_stay: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    (st_q == SMR_ST_LOW && !supply_ok)
    |=> st_q == SMR_ST_LOW)
    else $error("low left without supply");

  a_hold_reset: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    st_q == SMR_ST_HOLD
    |-> reset_out)
    else $error("reset low during hold");

  a_hold_enter: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    (st_q == SMR_ST_LOW && supply_ok)
    |=> st_q == SMR_ST_HOLD)
    else $error("hold not entered");

  a_hold_exit: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    (st_q == SMR_ST_HOLD && supply_ok && hold_done)
    |=> st_q == SMR_ST_RUN)
    else $error("hold not left");

  a_run_release: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    (st_q == SMR_ST_RUN && supply_ok && !manual_reset_input)
    |=> !reset_out)
    else $error("reset not released");

  a_hold_length: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
    (st_q == SMR_ST_HOLD && hold_done)
    |-> hold_cyc_q >= $past(chk_limit))
    else $error("hold shorter than selected");

  a_timer_clear: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
    st_q != SMR_ST_HOLD
    |=> !hold_done)
    else $error("timer not cleared");

  a_manual_release: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
    $fell(reset_out)
    |-> !$past(manual_reset_input))
    else $error("release during manual reset");

  a_state_legal: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    st_q inside {SMR_ST_LOW, SMR_ST_HOLD, SMR_ST_RUN})
    else $error("illegal state");
endmodule

/* File: smr_cfg.svh */
// Timing and counter width constants for the supply monitor reset block
`ifndef SMR_CFG_SVH
`define SMR_CFG_SVH
`define SMR_CLK_HZ      50000000
`define SMR_HOLD_MS_0   1
`define SMR_HOLD_MS_1   50
`define SMR_HOLD_MS_2   100
`define SMR_HOLD_MS_3   200
`define SMR_MS_PER_S    1000
`define SMR_CNT_W       24
`endif

/* File: smr_pkg.sv */
// Types for the supply monitor reset block
package smr_pkg;
  typedef enum logic [1:0] {
    SMR_ST_LOW   = 2'b00,
    SMR_ST_HOLD  = 2'b01,
    SMR_ST_RUN   = 2'b10
  } smr_state_t;
  typedef logic [1:0] smr_sel_t;
endpackage

/* File: smr_hold_timer.sv */
// Hold interval counter with per-select terminal counts
`timescale 1ns/1ps
`include "smr_cfg.svh"
module smr_hold_timer #(
  parameter int                   CW     = `SMR_CNT_W,
  parameter logic [CW-1:0]        LIMIT0 = CW'(`SMR_CLK_HZ / `SMR_MS_PER_S * `SMR_HOLD_MS_0),
  parameter logic [CW-1:0]        LIMIT1 = CW'(`SMR_CLK_HZ / `SMR_MS_PER_S * `SMR_HOLD_MS_1),
  parameter logic [CW-1:0]        LIMIT2 = CW'(`SMR_CLK_HZ / `SMR_MS_PER_S * `SMR_HOLD_MS_2),
  parameter logic [CW-1:0]        LIMIT3 = CW'(`SMR_CLK_HZ / `SMR_MS_PER_S * `SMR_HOLD_MS_3)
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               clear,
  input  wire smr_pkg::smr_sel_t  sel,
  output logic                    done
);
  import smr_pkg::*;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] limit;
  logic          done_d;
  always_comb begin
    case (sel)
      2'h0:    limit = LIMIT0;
      2'h1:    limit = LIMIT1;
      2'h2:    limit = LIMIT2;
      default: limit = LIMIT3;
    endcase
    // Clear restarts from zero  [RULE8]
    if (clear) begin
      cnt_d = '0;
    end else if (cnt_q < limit) begin
      cnt_d = cnt_q + CW'(1);
    end else begin
      cnt_d = cnt_q;
    end
    done_d = !clear && (cnt_d >= limit);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      done  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done  <= done_d;
    end
  end
endmodule

/* File: smr_host_model.sv */
// Host side model: pulled-up open-drain pins and a manual reset button
`timescale 1ns/1ps
module smr_host_model (
  input  wire logic reset_oe,
  input  wire logic flag_oe,
  input  wire logic press,
  output logic      reset_pin,
  output logic      flag_pin,
  output logic      manual_reset_input
);
  // Pull-up wins whenever the device lets go of a pin
  assign reset_pin = !reset_oe;
  assign flag_pin = !flag_oe;
  assign manual_reset_input = press;
endmodule

/* File: supply_monitor_reset_tb_top.sv */
// Testbench for the supply monitor reset block
`timescale 1ns/1ps
module supply_monitor_reset_tb_top;
  logic clk, rst_n, supply_ok, mon_in, press, sel0, sel1, man;
  logic reset_out, reset_oe, flag, flag_oe, reset_pin, flag_pin;
  int   n_fail, cmp_count;
  // Short hold counts keep the run small; the design defaults are milliseconds
  localparam int H0 = 5;
  localparam int H1 = 10;
  localparam int H2 = 15;
  localparam int H3 = 20;
  smr_top #(.HOLD0(24'(H0)), .HOLD1(24'(H1)), .HOLD2(24'(H2)), .HOLD3(24'(H3))) dut_u (
    .clk(clk), .rst_n(rst_n), .supply_ok(supply_ok),
    .second_monitor_input(mon_in), .manual_reset_input(man),
    .timeout_select_bit0(sel0), .timeout_select_bit1(sel1), .reset_out(reset_out),
    .reset_oe(reset_oe), .second_monitor_flag(flag), .second_monitor_oe(flag_oe));
  smr_host_model host_u (.reset_oe(reset_oe), .flag_oe(flag_oe), .press(press),
    .reset_pin(reset_pin), .flag_pin(flag_pin), .manual_reset_input(man));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait for release; the bound covers the longest simulated hold
  task automatic wait_rel;
    for (int i = 0; i < H3 + 8 && reset_pin; i++) cyc(1);
    chk(reset_pin, 1'b0);
    if (reset_pin !== 1'b0) test_done;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_flag;
    for (int i = 0; i < 4; i++) begin
      mon_in = ~i[0];
      cyc(1);
      chk(flag_pin, mon_in);
      chk(flag, mon_in);
    end
  endtask
  // Dip part way: without a restart the release would come early
  task automatic t_hold;
    supply_ok = 1'b1;
    cyc(3);
    supply_ok = 1'b0;
    cyc(2);
    chk(reset_pin, 1'b1);
    supply_ok = 1'b1;
    cyc(H0 + 1);
    chk(reset_pin, 1'b1);
    cyc(1);
    chk(reset_pin, 1'b0);
  endtask
  // Release falls on the edge hold+1 after the edge that sees the supply good
  task automatic t_sel(input int s, input int lim);
    supply_ok = 1'b0;
    {sel1, sel0} = s[1:0];
    cyc(2);
    supply_ok = 1'b1;
    cyc(lim + 1);
    chk(reset_pin, 1'b1);
    cyc(1);
    chk(reset_pin, 1'b0);
  endtask
  task automatic t_rst;
    mon_in = 1'b1;
    cyc(2);
    rst_n = 1'b0;
    cyc(1);
    chk(reset_pin, 1'b1);
    rst_n = 1'b1;
    cyc(1);
    chk(flag_pin, 1'b1);
    chk(reset_pin, 1'b1);
    cyc(H0);
    chk(reset_pin, 1'b1);
    cyc(1);
    chk(reset_pin, 1'b0);
  endtask
  task automatic t_drop;
    supply_ok = 1'b0;
    cyc(2);
    chk(reset_pin, 1'b1);
    supply_ok = 1'b1;
    wait_rel();
  endtask
  task automatic t_manual;
    press = 1'b1;
    cyc(3);
    chk(reset_pin, 1'b1);
    chk(reset_out, 1'b1);
    press = 1'b0;
    cyc(1);
    chk(reset_pin, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    supply_ok = 1'b0;
    mon_in = 1'b0;
    press = 1'b0;
    sel0 = 1'b0;
    sel1 = 1'b0;
    cyc(6);
    rst_n = 1'b1;
    cyc(2);
    chk(reset_pin, 1'b1);
    t_flag();
    t_hold();
    t_drop();
    t_manual();
    t_sel(1, H1);
    t_sel(2, H2);
    t_sel(3, H3);
    t_sel(0, H0);
    t_rst();
    test_done();
  end
endmodule
